//--- src/ifpr_pkg.sv
/*
  Constants for the interrupt flag and priority register block: offsets, field
  positions, implemented-bit masks and reset values.
  Assumes a 32-bit APB slave in which each 16-bit register sits in the low half of one word.
*/
package ifpr_pkg;
  localparam int REG_W = 16;
  localparam int PRIO_W = 3;

  localparam logic [7:0] OFS_FLAG2 = 8'h00;
  localparam logic [7:0] OFS_FLAG4 = 8'h04;
  localparam logic [7:0] OFS_PRIO = 8'h08;

  localparam int FLAG2_CAN1_RX = 2;
  localparam int FLAG2_SPIB_EVT = 1;
  localparam int FLAG2_SPIB_ERR = 0;
  localparam logic [REG_W-1:0] FLAG2_IMPL = 16'h0007;
  localparam logic [REG_W-1:0] FLAG2_RESET = 16'h0000;

  localparam int FLAG4_CAN2_TX = 7;
  localparam int FLAG4_CAN1_TX = 6;
  localparam int FLAG4_DMA7 = 5;
  localparam int FLAG4_DMA6 = 4;
  localparam int FLAG4_UARTB_ERR = 2;
  localparam int FLAG4_UARTA_ERR = 1;
  localparam logic [REG_W-1:0] FLAG4_IMPL = 16'h00f6;
  localparam logic [REG_W-1:0] FLAG4_RESET = 16'h0000;

  localparam int PRIO_TIMER_F_LSB = 12;
  localparam int PRIO_DMA4_LSB = 8;
  localparam int PRIO_OUTCMP_H_LSB = 0;
  localparam logic [REG_W-1:0] PRIO_IMPL = 16'h7707;
  localparam logic [PRIO_W-1:0] PRIO_FIELD_RESET = 3'h4;
  localparam logic [PRIO_W-1:0] PRIO_DISABLED = 3'h0;
endpackage

//--- src/ifpr_flag_if.sv
/*
  Carrier between the top and one flag register: source events, the software
  write and the stored flags.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface ifpr_flag_if #(parameter int W = 16);
  logic [W-1:0] events;
  logic write;
  logic [W-1:0] wdata;
  logic [W-1:0] flags;
  modport owner (input events, input write, input wdata, output flags);
  modport user (output events, output write, output wdata, input flags);
endinterface

//--- src/ifpr_flag_reg.sv
/*
  One sticky interrupt flag register with a mask of implemented bits.
  Assumes events are synchronous one-cycle or level requests on clk.
*/
`timescale 1ns/1ns
module ifpr_flag_reg #(
  parameter int W = 16,
  parameter logic [W-1:0] IMPL = '1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic nrst,
  ifpr_flag_if.owner bus
);
  logic [W-1:0] flags_reg;
  logic [W-1:0] flags_next;

  if (W < 1 || W > 32) begin : g_bad_width
    $error("ifpr_flag_reg width must be 1 to 32");
  end

  // A request in the same cycle as a software clear wins, so no event is lost.
  always_comb begin
    flags_next = bus.write ? bus.wdata : flags_reg;
    flags_next = (flags_next | bus.events) & IMPL;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_reg <= RESET_VAL & IMPL;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign bus.flags = flags_reg;
endmodule

//--- src/ifpr_top.sv
/*
  Interrupt flag registers two and four and the timer, DMA and output-compare
  priority register, reached over APB.
  Assumes peripheral requests are synchronous to clk; one wait state per transfer.
*/
`timescale 1ns/1ns
module ifpr_top
  import ifpr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic can1_rx_ready_req,
  input wire logic spi_b_event_req,
  input wire logic spi_b_error_req,
  input wire logic can2_tx_req,
  input wire logic can1_tx_req,
  input wire logic dma_ch7_done_req,
  input wire logic dma_ch6_done_req,
  input wire logic uart_b_error_req,
  input wire logic uart_a_error_req,
  output logic [REG_W-1:0] flag2State,
  output logic [REG_W-1:0] flag4State,
  output logic [PRIO_W-1:0] timer_f_priority,
  output logic [PRIO_W-1:0] dma_ch4_priority,
  output logic [PRIO_W-1:0] outcmp_h_priority,
  output logic timerFEnabled,
  output logic dmaCh4Enabled,
  output logic outcmpHEnabled
);
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("ifpr_top address width must be 8 to 32");
  end

  ifpr_flag_if #(.W(REG_W)) flag2Bus ();
  ifpr_flag_if #(.W(REG_W)) flag4Bus ();

  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [REG_W-1:0] prio_reg;
  logic [REG_W-1:0] prio_next;
  logic [2:0] enable_reg;
  logic [2:0] enable_next;
  logic hitFlag2;
  logic hitFlag4;
  logic hitPrio;
  logic mapped;
  logic commit;
  logic [REG_W-1:0] readWord;

  assign hitFlag2 = paddr == ADDR_W'(OFS_FLAG2);
  assign hitFlag4 = paddr == ADDR_W'(OFS_FLAG4);
  assign hitPrio = paddr == ADDR_W'(OFS_PRIO);
  assign mapped = hitFlag2 | hitFlag4 | hitPrio;
  // A write lands only at the edge where the master sees pready high.
  assign commit = psel & penable & pready_reg & pwrite & mapped;

  assign flag2Bus.events = (REG_W'(can1_rx_ready_req) << FLAG2_CAN1_RX)
                         | (REG_W'(spi_b_event_req) << FLAG2_SPIB_EVT)
                         | (REG_W'(spi_b_error_req) << FLAG2_SPIB_ERR);
  assign flag2Bus.write = commit & hitFlag2;
  assign flag2Bus.wdata = pwdata[REG_W-1:0];

  assign flag4Bus.events = (REG_W'(can2_tx_req) << FLAG4_CAN2_TX)
                         | (REG_W'(can1_tx_req) << FLAG4_CAN1_TX)
                         | (REG_W'(dma_ch7_done_req) << FLAG4_DMA7)
                         | (REG_W'(dma_ch6_done_req) << FLAG4_DMA6)
                         | (REG_W'(uart_b_error_req) << FLAG4_UARTB_ERR)
                         | (REG_W'(uart_a_error_req) << FLAG4_UARTA_ERR);
  assign flag4Bus.write = commit & hitFlag4;
  assign flag4Bus.wdata = pwdata[REG_W-1:0];

  ifpr_flag_reg #(
    .W(REG_W),
    .IMPL(FLAG2_IMPL),
    .RESET_VAL(FLAG2_RESET)
  ) u_flag2 (
    .clk(clk),
    .nrst(nrst),
    .bus(flag2Bus)
  );

  ifpr_flag_reg #(
    .W(REG_W),
    .IMPL(FLAG4_IMPL),
    .RESET_VAL(FLAG4_RESET)
  ) u_flag4 (
    .clk(clk),
    .nrst(nrst),
    .bus(flag4Bus)
  );

  always_comb begin
    prio_next = prio_reg;
    if (commit && hitPrio) begin
      prio_next = pwdata[REG_W-1:0] & PRIO_IMPL;
    end
    enable_next[2] = prio_next[PRIO_TIMER_F_LSB +: PRIO_W] != PRIO_DISABLED;
    enable_next[1] = prio_next[PRIO_DMA4_LSB +: PRIO_W] != PRIO_DISABLED;
    enable_next[0] = prio_next[PRIO_OUTCMP_H_LSB +: PRIO_W] != PRIO_DISABLED;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prio_reg <= (REG_W'(PRIO_FIELD_RESET) << PRIO_TIMER_F_LSB)
                | (REG_W'(PRIO_FIELD_RESET) << PRIO_DMA4_LSB)
                | (REG_W'(PRIO_FIELD_RESET) << PRIO_OUTCMP_H_LSB);
      enable_reg <= {3{PRIO_FIELD_RESET != PRIO_DISABLED}};
    end else begin
      prio_reg <= prio_next;
      enable_reg <= enable_next;
    end
  end

  always_comb begin
    readWord = '0;
    if (hitFlag2) begin
      readWord = flag2Bus.flags;
    end else if (hitFlag4) begin
      readWord = flag4Bus.flags;
    end else if (hitPrio) begin
      readWord = prio_reg;
    end
  end

  // One wait state lets read data come from a flop without a path from paddr.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      if (psel && penable && !pready_reg) begin
        prdata_reg <= (pwrite || !mapped) ? 32'h0 : {16'h0, readWord};
        pslverr_reg <= ~mapped;
      end else begin
        prdata_reg <= 32'h0;
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign flag2State = flag2Bus.flags;
  assign flag4State = flag4Bus.flags;
  assign timer_f_priority = prio_reg[PRIO_TIMER_F_LSB +: PRIO_W];
  assign dma_ch4_priority = prio_reg[PRIO_DMA4_LSB +: PRIO_W];
  assign outcmp_h_priority = prio_reg[PRIO_OUTCMP_H_LSB +: PRIO_W];
  assign timerFEnabled = enable_reg[2];
  assign dmaCh4Enabled = enable_reg[1];
  assign outcmpHEnabled = enable_reg[0];
endmodule

//--- tb/ifpr_assertions.sv
/* Checker for the flag and priority block.
   Bound to ifpr_top and sees only its ports. */
`timescale 1ns/1ns
module ifpr_assertions
  import ifpr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic can1_rx_ready_req,
  input wire logic spi_b_event_req,
  input wire logic spi_b_error_req,
  input wire logic [REG_W-1:0] flag2State,
  input wire logic [REG_W-1:0] flag4State,
  input wire logic [PRIO_W-1:0] timer_f_priority,
  input wire logic timerFEnabled
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Only a committed write to flag register two may drop its CAN1 receive flag (bit 2).
  property p_sticky;
    $fell(flag2State[2]) |-> $past(pready && pwrite && paddr == ADDR_W'(OFS_FLAG2));
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_can1; can1_rx_ready_req |=> flag2State[2]; endproperty
  a_can1: assert property (p_can1) else $error("can1 flag");
  property p_spiev; spi_b_event_req |=> flag2State[1]; endproperty
  a_spiev: assert property (p_spiev) else $error("spi event flag");
  property p_spierr; spi_b_error_req |=> flag2State[0]; endproperty
  a_spierr: assert property (p_spierr) else $error("spi error flag");
  property p_en; timerFEnabled == (timer_f_priority != 3'h0); endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  property p_prio;
    pready && !pwrite && !pslverr && paddr == ADDR_W'(OFS_PRIO)
      |-> prdata[14:12] == timer_f_priority;
  endproperty
  a_prio: assert property (p_prio) else $error("timer field");
  property p_unf; flag2State[15:3] == 13'h0 && (flag4State & ~FLAG4_IMPL) == 16'h0; endproperty
  a_unf: assert property (p_unf) else $error("unused flag");
  property p_unr; pready && !pwrite |-> prdata[31:16] == 16'h0; endproperty
  a_unr: assert property (p_unr) else $error("upper half");
endmodule
bind ifpr_top ifpr_assertions #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .nrst(nrst),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .can1_rx_ready_req(can1_rx_ready_req), .spi_b_event_req(spi_b_event_req),
  .spi_b_error_req(spi_b_error_req), .flag2State(flag2State), .flag4State(flag4State),
  .timer_f_priority(timer_f_priority), .timerFEnabled(timerFEnabled));

//--- tb/ifpr_sources.sv
/* Model of the peripheral request sources.
   Assumes the bench commands pulses on clk. */
`timescale 1ns/1ns
module ifpr_sources (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [8:0] pulseMask,
  output logic [8:0] req
);
  // Registered so requests move just after an edge, as a real peripheral's do.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req <= 9'h000;
    end else begin
      req <= pulseMask;
    end
  end
endmodule

//--- tb/testbench.sv
/* Testbench for ifpr_top: APB tasks and request pulses.
   Assumes each transfer is answered within a few cycles. */
`timescale 1ns/1ns
module testbench;
  import ifpr_pkg::*;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, et, ed, eo, se;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [8:0] pulseMask = 9'h000, req;
  logic [2:0] pt, pd, po;
  int fails = 0, tests_run = 0;
  always #25 clk = ~clk;
  ifpr_sources SRC (.clk(clk), .nrst(nrst), .pulseMask(pulseMask), .req(req));
  ifpr_top DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .can1_rx_ready_req(req[8]), .spi_b_event_req(req[7]), .spi_b_error_req(req[6]),
    .can2_tx_req(req[5]), .can1_tx_req(req[4]), .dma_ch7_done_req(req[3]),
    .dma_ch6_done_req(req[2]), .uart_b_error_req(req[1]), .uart_a_error_req(req[0]),
    .flag2State(), .flag4State(), .timer_f_priority(pt), .dma_ch4_priority(pd),
    .outcmp_h_priority(po), .timerFEnabled(et), .dmaCh4Enabled(ed), .outcmpHEnabled(eo));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    // A hung slave ends the run here rather than stalling every later check.
    if (pready !== 1'h1) begin
      $display("Error pready expected 1 seen %b", pready);
      fails++;
      complete_run();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic fire(input logic [8:0] m);
    @(posedge clk);
    pulseMask <= m;
    @(posedge clk);
    pulseMask <= 9'h000;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    rdchk(OFS_FLAG2, 32'h0, "flag2");
    rdchk(OFS_FLAG4, 32'h0, "flag4");
    rdchk(OFS_PRIO, 32'h4404, "prio");
    chk("prio slave error", 32'h0, {31'h0, se});
    rdchk(8'h0c, 32'h0, "unmapped");
    chk("unmapped slave error", 32'h1, {31'h0, se});
    for (int i = 0; i < 3; i++) begin
      fire(9'h100 >> i);
      rdchk(OFS_FLAG2, 32'h7 & ~(32'h3 >> i), "flag2 set");
    end
    apb(1'h1, OFS_FLAG2, 32'hffff_fff8);
    rdchk(OFS_FLAG2, 32'h0, "flag2 clear");
    apb(1'h1, OFS_FLAG2, 32'hffff_ffff);
    rdchk(OFS_FLAG2, 32'h7, "flag2 mask");
    fire(9'h03f);
    rdchk(OFS_FLAG4, 32'hf6, "flag4 set");
    for (int v = 0; v < 8; v++) begin
      apb(1'h1, OFS_PRIO, {16'hffff, 1'h1, v[2:0], 1'h1, v[2:0], 5'h1f, v[2:0]});
      rdchk(OFS_PRIO, {17'h0, v[2:0], 1'h0, v[2:0], 5'h0, v[2:0]}, "prio rw");
      chk("timer prio", {28'h0, v != 0, v[2:0]}, {28'h0, et, pt});
      chk("dma prio", {28'h0, v != 0, v[2:0]}, {28'h0, ed, pd});
      chk("outcmp prio", {28'h0, v != 0, v[2:0]}, {28'h0, eo, po});
    end
    apb(1'h1, 8'h0c, 32'h0);
    chk("write slave error", 32'h1, {31'h0, se});
    rdchk(OFS_PRIO, 32'h7707, "prio kept");
    @(posedge clk);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    rdchk(OFS_FLAG2, 32'h0, "flag2 reset");
    rdchk(OFS_PRIO, 32'h4404, "prio reset");
    chk("timer prio reset", 32'hc, {28'h0, et, pt});
    complete_run();
  end
endmodule
